// ### verilog/pdl_regs.svh
// register offsets, reset values and timing constants for the pulse-to-level converter
`ifndef PDL_REGS_SVH
`define PDL_REGS_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define PDL_CTRL_OFS      12'h000
`define PDL_STATUS_OFS    12'h004
`define PDL_INT_STAT_OFS  12'h008
`define PDL_INT_MASK_OFS  12'h00C
`define PDL_MODE0_OFS     12'h010
`define PDL_LEVEL0_OFS    12'h030
`define PDL_HAND0_OFS     12'h050
`define PDL_ANA0_OFS      12'h070
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PDL_CTRL_LOAD_REQ_BIT  0
`define PDL_STATUS_LOAD_BIT    0
`define PDL_STATUS_LOADED_BIT  1
`define PDL_STATUS_LOST_LSB    8
`define PDL_INT_DONE_LSB       0
`define PDL_INT_LOST_LSB       8
`define PDL_INT_LOAD_END_BIT   16
`define PDL_MODE_SEL_LSB       0
`define PDL_MODE_USE_LSB       4
`define PDL_MODE_INV_BIT       8
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PDL_INT_MASK_RST  32'h0000_0000
`define PDL_HAND_RST      7'h64
`define PDL_MODE_RST      2'h2
// ----------------------------------------------------------------
// timing, in units named; cycle counts derived at 200 MHz
// ----------------------------------------------------------------
`define PDL_CLK_HZ        200000000
`define PDL_TICK_MS       100
`define PDL_TICK_CYC      ((`PDL_CLK_HZ / 1000) * `PDL_TICK_MS)
`define PDL_TICK_10HZ     10
`define PDL_MIN_PULSE_S   1
`define PDL_FULL_SCALE_S  10
`define PDL_LOST_S        60
`define PDL_LOAD_WIN_S    10
`define PDL_GLITCH_MS     30
`define PDL_PWM_PERIOD    7'd100
`endif

// ### verilog/pdl_pkg.sv
// types for the pulse-to-level converter
package pdl_pkg;
  typedef enum logic [1:0] {
    SEL_OFF,
    SEL_HAND,
    SEL_AUTO
  } sel_t;
  typedef enum logic [1:0] {
    USE_PULSE,
    USE_BINARY,
    USE_ANALOG
  } use_t;
  typedef struct packed {
    logic [6:0] level;
    logic       lost;
    logic       led_in;
    logic       led_out;
  } chan_out_t;
  typedef enum logic {
    BOOT_LOAD,
    BOOT_RUN
  } boot_t;
endpackage

// ### verilog/pulse_level_conv.sv
// six-channel pulse on-time to output level converter with apb registers
// What this block does
// RQ1: auto output equals on-time, 1V/s, 10V cap
// RQ2: level held in 0.1V steps
// RQ3: no pulse in 60s forces zero
// RQ4: lost channel flashes input indicator 4Hz
// RQ5: flash repeats until next pulse arrives
// RQ6: pulse under one second gives zero
// RQ7: six independent input-output-selector channels
// RQ8: off selector holds output at zero
// RQ9: hand selector drives manual set level
// RQ10: auto selector uses paired pulse only
// RQ11: ac burst counted as one on-time
// RQ12: pulse use: indicator follows input
// RQ13: binary use: contact shown, optional invert
// RQ14: analog use: about ten brightness steps
// RQ15: output indicator brightness follows level
// RQ16: first ten seconds: double-blink heartbeat
// RQ17: load only in window, then 1Hz beat
// RQ18: serial port is outside this block
// RQ19: measure edge to edge, restart timeout

`include "pdl_regs.svh"
module pulse_level_conv #(
  parameter int CHANNELS = 6,
  parameter int TICK_CYC = `PDL_TICK_CYC,
  parameter int GLITCH_CYC = (`PDL_CLK_HZ / 1000) * `PDL_GLITCH_MS
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rstn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // channel pins
  input  wire logic [CHANNELS-1:0] pulse_in,
  input  wire logic [CHANNELS-1:0] hoa_hand,
  input  wire logic [CHANNELS-1:0] hoa_off,
  output logic      [6:0]          out_level [CHANNELS],
  output logic      [CHANNELS-1:0] led_in,
  output logic      [CHANNELS-1:0] led_out,
  // system
  output logic                     led_beat,
  output logic                     load_window,
  output logic                     irq
);
  if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad_channels
    $error("channels must be 1 to 8");
  end
  if (TICK_CYC < 2 || GLITCH_CYC < 1 || GLITCH_CYC >= TICK_CYC) begin : g_bad_timing
    $error("bad timing parameters");
  end

  // ----------------------------------------------------------------
  // 10 Hz tick and pwm slot counter
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt;
  logic        tick;
  logic [6:0]  pwm_cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end
  assign tick = (tick_cnt == 32'(TICK_CYC - 1));

  // pwm runs on clk; 100 slots give the brightness resolution of one level step
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_cnt <= 7'h00;
    end else if (pwm_cnt == `PDL_PWM_PERIOD - 7'd1) begin
      pwm_cnt <= 7'h00;
    end else begin
      pwm_cnt <= pwm_cnt + 7'h01;
    end
  end

  // slow phase: 0..9 within each second
  logic [3:0] phase;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase <= 4'h0;
    end else if (tick) begin
      phase <= (phase == 4'h9) ? 4'h0 : phase + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // heartbeat and loading window
  // ----------------------------------------------------------------
  pdl_pkg::boot_t boot;
  logic [6:0]     boot_ticks;
  logic           load_req;
  logic           loaded;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boot       <= pdl_pkg::BOOT_LOAD;
      boot_ticks <= 7'h00;
    end else if (tick && boot == pdl_pkg::BOOT_LOAD) begin
      boot_ticks <= boot_ticks + 7'h01;
      if (boot_ticks == 7'(`PDL_LOAD_WIN_S * `PDL_TICK_10HZ - 1)) begin
        boot <= pdl_pkg::BOOT_RUN; // see RQ17
      end
    end
  end
  assign load_window = (boot == pdl_pkg::BOOT_LOAD);

  // two quick blips then pause, vs one blip a second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      led_beat <= 1'b0;
    end else if (boot == pdl_pkg::BOOT_LOAD) begin
      led_beat <= (phase == 4'h0) || (phase == 4'h2); // see RQ16
    end else begin
      led_beat <= (phase == 4'h0); // see RQ17
    end
  end

  // ----------------------------------------------------------------
  // per-channel measurement
  // ----------------------------------------------------------------
  pdl_pkg::sel_t   sel     [CHANNELS];
  pdl_pkg::use_t   use_m   [CHANNELS];
  logic            inv     [CHANNELS];
  logic [6:0]      hand_lv [CHANNELS];
  logic [6:0]      ana_lv  [CHANNELS];
  pdl_pkg::chan_out_t ch   [CHANNELS];
  logic [CHANNELS-1:0] ev_done;
  logic [CHANNELS-1:0] ev_lost;

  function automatic logic [6:0] ten_step(input logic [6:0] v);
    ten_step = 7'((v / 7'd10) * 7'd10);
  endfunction

  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    logic [1:0]  sync;
    logic [31:0] hold_cnt;
    logic        active;
    logic [7:0]  on_ticks;
    logic [9:0]  idle_ticks;
    logic [6:0]  meas;
    logic        was_active;
    logic [6:0]  drv;
    logic [1:0]  off_sync;
    logic [1:0]  hand_sync;
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        sync <= 2'h0;
      end else begin
        sync <= {sync[0], pulse_in[i]};
      end
    end
    // selector switches are pins too: two flops before the decode
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        off_sync  <= 2'h0;
        hand_sync <= 2'h0;
      end else begin
        off_sync  <= {off_sync[0], hoa_off[i]};
        hand_sync <= {hand_sync[0], hoa_hand[i]};
      end
    end
    // an ac burst drops to zero each half cycle; hold active across the gaps
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        hold_cnt <= 32'h0000_0000;
        active   <= 1'b0;
      end else if (sync[1]) begin
        hold_cnt <= 32'(GLITCH_CYC); // see RQ11
        active   <= 1'b1;
      end else if (hold_cnt != 32'h0000_0000) begin
        hold_cnt <= hold_cnt - 32'h0000_0001;
      end else begin
        active <= 1'b0;
      end
    end
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        was_active <= 1'b0;
        on_ticks   <= 8'h00;
        idle_ticks <= 10'h000;
        meas       <= 7'h00;
        ch[i].lost <= 1'b0;
        ev_done[i] <= 1'b0;
        ev_lost[i] <= 1'b0;
      end else begin
        was_active <= active;
        ev_done[i] <= 1'b0;
        ev_lost[i] <= 1'b0;
        if (active && !was_active) begin
          on_ticks   <= 8'h00; // see RQ19
          idle_ticks <= 10'h000;
          ch[i].lost <= 1'b0; // see RQ5
        end else if (!active && was_active) begin
          ev_done[i] <= 1'b1;
          if (on_ticks < 8'(`PDL_MIN_PULSE_S * `PDL_TICK_10HZ)) begin
            meas <= 7'h00; // see RQ6
          end else if (on_ticks >= 8'(`PDL_FULL_SCALE_S * `PDL_TICK_10HZ)) begin
            meas <= 7'(`PDL_FULL_SCALE_S * `PDL_TICK_10HZ); // see RQ1
          end else begin
            meas <= on_ticks[6:0]; // see RQ2
          end
        end else if (tick) begin
          // a tick on an edge cycle is dropped: one step of jitter
          if (active && on_ticks != 8'hFF) begin
            on_ticks <= on_ticks + 8'h01;
          end
          if (idle_ticks == 10'(`PDL_LOST_S * `PDL_TICK_10HZ - 1)) begin
            if (!ch[i].lost) begin
              ev_lost[i] <= 1'b1;
            end
            ch[i].lost <= 1'b1; // see RQ3
            meas       <= 7'h00;
          end else begin
            idle_ticks <= idle_ticks + 10'h001;
          end
        end
      end
    end
    // pin selector wins over software mode: it is the field override
    always_comb begin
      if (off_sync[1] || (!hand_sync[1] && sel[i] == pdl_pkg::SEL_OFF)) begin
        drv = 7'h00; // see RQ8
      end else if (hand_sync[1] || sel[i] == pdl_pkg::SEL_HAND) begin
        drv = hand_lv[i]; // see RQ9
      end else begin
        drv = meas; // see RQ10
      end
    end
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ch[i].level   <= 7'h00;
        ch[i].led_in  <= 1'b0;
        ch[i].led_out <= 1'b0;
      end else begin
        ch[i].level   <= drv;
        ch[i].led_out <= (drv >= 7'(`PDL_TICK_10HZ)) && (pwm_cnt < drv); // see RQ15
        if (ch[i].lost) begin
          ch[i].led_in <= !phase[0] && (phase < 4'h8); // see RQ4
        end else begin
          unique case (use_m[i])
            pdl_pkg::USE_BINARY: ch[i].led_in <= sync[1] ^ inv[i]; // see RQ13
            pdl_pkg::USE_ANALOG: ch[i].led_in <= pwm_cnt < ten_step(ana_lv[i]); // see RQ14
            default:             ch[i].led_in <= active; // see RQ12
          endcase
        end
      end
    end
    assign out_level[i] = ch[i].level; // see RQ7
    assign led_in[i]    = ch[i].led_in;
    assign led_out[i]   = ch[i].led_out;
  end

  // ----------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------
  logic        wr;
  logic        rd_ok;
  logic [31:0] int_stat;
  logic [31:0] int_mask;
  logic [31:0] ev_all;
  logic        load_end;
  assign wr      = psel && penable && pwrite; // see RQ18
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_ok;
  assign load_end = tick && boot == pdl_pkg::BOOT_LOAD
                    && boot_ticks == 7'(`PDL_LOAD_WIN_S * `PDL_TICK_10HZ - 1);
  always_comb begin
    ev_all = 32'h0000_0000;
    ev_all[`PDL_INT_DONE_LSB +: CHANNELS] = ev_done;
    ev_all[`PDL_INT_LOST_LSB +: CHANNELS] = ev_lost;
    ev_all[`PDL_INT_LOAD_END_BIT] = load_end;
  end

  // set beats clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_stat <= 32'h0000_0000;
      int_mask <= `PDL_INT_MASK_RST;
    end else begin
      if (wr && paddr == `PDL_INT_STAT_OFS) begin
        int_stat <= (int_stat & ~pwdata) | ev_all;
      end else begin
        int_stat <= int_stat | ev_all;
      end
      if (wr && paddr == `PDL_INT_MASK_OFS) begin
        int_mask <= pwdata;
      end
    end
  end
  assign irq = |(int_stat & int_mask);

  // a load request outside the window is ignored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      load_req <= 1'b0;
      loaded   <= 1'b0;
    end else if (wr && paddr == `PDL_CTRL_OFS) begin
      load_req <= pwdata[`PDL_CTRL_LOAD_REQ_BIT] && load_window; // see RQ17
      loaded   <= loaded || (pwdata[`PDL_CTRL_LOAD_REQ_BIT] && load_window);
    end
  end

  for (genvar i = 0; i < CHANNELS; i++) begin : g_cfg
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        sel[i]     <= pdl_pkg::SEL_AUTO;
        use_m[i]   <= pdl_pkg::USE_PULSE;
        inv[i]     <= 1'b0;
        hand_lv[i] <= `PDL_HAND_RST;
        ana_lv[i]  <= 7'h00;
      end else if (wr) begin
        if (paddr == `PDL_MODE0_OFS + 12'(4 * i)) begin
          if (pwdata[1:0] != 2'h3) begin
            sel[i] <= pdl_pkg::sel_t'(pwdata[`PDL_MODE_SEL_LSB +: 2]);
          end
          if (pwdata[5:4] != 2'h3) begin
            use_m[i] <= pdl_pkg::use_t'(pwdata[`PDL_MODE_USE_LSB +: 2]);
          end
          inv[i] <= pwdata[`PDL_MODE_INV_BIT];
        end
        if (paddr == `PDL_HAND0_OFS + 12'(4 * i)) begin
          hand_lv[i] <= (pwdata[6:0] > 7'd100) ? 7'd100 : pwdata[6:0]; // see RQ9
        end
        if (paddr == `PDL_ANA0_OFS + 12'(4 * i)) begin
          ana_lv[i] <= (pwdata[6:0] > 7'd100) ? 7'd100 : pwdata[6:0];
        end
      end
    end
  end

  // read data loads in the setup cycle so it stands at the access edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (paddr == `PDL_CTRL_OFS) prdata <= {31'h0, load_req};
      if (paddr == `PDL_INT_STAT_OFS) prdata <= int_stat;
      if (paddr == `PDL_INT_MASK_OFS) prdata <= int_mask;
      if (paddr == `PDL_STATUS_OFS) begin
        prdata[`PDL_STATUS_LOAD_BIT]   <= load_window;
        prdata[`PDL_STATUS_LOADED_BIT] <= loaded;
        for (int i = 0; i < CHANNELS; i++) prdata[`PDL_STATUS_LOST_LSB + i] <= ch[i].lost;
      end
      for (int i = 0; i < CHANNELS; i++) begin
        if (paddr == `PDL_MODE0_OFS + 12'(4 * i)) prdata <= {23'h0, inv[i], 2'h0, use_m[i], 2'h0, sel[i]};
        if (paddr == `PDL_LEVEL0_OFS + 12'(4 * i)) prdata <= {25'h0, ch[i].level};
        if (paddr == `PDL_HAND0_OFS + 12'(4 * i)) prdata <= {25'h0, hand_lv[i]};
        if (paddr == `PDL_ANA0_OFS + 12'(4 * i)) prdata <= {25'h0, ana_lv[i]};
      end
    end
  end

  always_comb begin
    rd_ok = (paddr == `PDL_CTRL_OFS) || (paddr == `PDL_STATUS_OFS)
         || (paddr == `PDL_INT_STAT_OFS) || (paddr == `PDL_INT_MASK_OFS);
    for (int i = 0; i < CHANNELS; i++) begin
      if (paddr == `PDL_MODE0_OFS + 12'(4 * i) || paddr == `PDL_LEVEL0_OFS + 12'(4 * i)
          || paddr == `PDL_HAND0_OFS + 12'(4 * i) || paddr == `PDL_ANA0_OFS + 12'(4 * i)) begin
        rd_ok = 1'b1;
      end
    end
  end
endmodule

// ### verif/pulse_ctrl_model.sv
// remote pulsing controller model driving the six pulse pins
module pulse_ctrl_model (
  output logic [5:0] pulse_in,
  input  wire logic  clk
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pulse_in = 6'h00;
  // ----------------------------------------------------------------
  // pulse burst, all channels start together
  // ----------------------------------------------------------------
  // each burst restarts the timeout of every channel given a nonzero cycle count
  // ac lanes drop 3 of every 8 cycles, shorter than the input filter
  task automatic burst(input int cyc [6], input bit [5:0] ac);
    int mx;
    mx = 0;
    foreach (cyc[c]) if (cyc[c] > mx) mx = cyc[c];
    for (int n = 0; n <= mx; n++) begin
      @(posedge clk);
      for (int c = 0; c < 6; c++) pulse_in[c] <= n < cyc[c] && !(ac[c] && n % 8 > 4);
    end
  endtask
endmodule

// ### verif/pulse_level_conv_checker.sv
// assertion checker for the pulse-to-level converter
module pulse_level_conv_checker #(
  parameter int CHANNELS = 6
) (
  // clock and reset
  input wire logic                clk,
  input wire logic                rstn,
  // apb
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pready,
  input wire logic                pslverr,
  // channels
  input wire logic [CHANNELS-1:0] pulse_in,
  input wire logic [CHANNELS-1:0] hoa_off,
  input wire logic [6:0]          out_level [CHANNELS],
  input wire logic [CHANNELS-1:0] led_out,
  input wire logic                load_window
);
  logic over;
  logic sub;
  always_comb begin
    over = 1'b0;
    sub = 1'b0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (out_level[i] > 7'h64) over = 1'b1;
      if (out_level[i] != 7'h00 && out_level[i] < 7'h0A) sub = 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_ready_high: assert property (pready) else $error("pready low");
  a_slverr_access: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  a_level_cap: assert property (!over) else $error("level above full scale");
  a_no_sub_volt: assert property (!sub) else $error("level below one volt");
  a_window_stays_shut: assert property (!load_window |=> !load_window) else $error("window reopened");
  a_off_zero: assert property (hoa_off[0] [*4] |-> out_level[0] == 7'h00) else $error("off not zero");
  a_led_dark: assert property ((out_level[0] == 7'h00) [*8] |-> !led_out[0]) else $error("led lit at 0V");
  a_led_full: assert property ((out_level[0] == 7'h64) [*8] |-> led_out[0]) else $error("led dim at 10V");
  a_level_on_fall: assert property ($changed(out_level[0]) && out_level[0] != 7'h00 |-> !pulse_in[0])
    else $error("level moved mid pulse");
endmodule
bind pulse_level_conv pulse_level_conv_checker #(.CHANNELS(CHANNELS)) u_pulse_level_conv_checker (.clk(clk),
  .rstn(rstn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .pulse_in(pulse_in),
  .hoa_off(hoa_off), .out_level(out_level), .led_out(led_out), .load_window(load_window));

// ### verif/pulse_level_conv_tb_top.sv
// self-checking testbench for the pulse-to-level converter
module pulse_level_conv_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int T = 100;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, led_beat, load_window, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] pulse_in, hoa_hand, hoa_off, led_in, led_out;
  logic [6:0] out_level [6];
  logic err;
  int n_fail, tests_run, seed, n, m;
  int d [6];
  pulse_level_conv #(.TICK_CYC(T), .GLITCH_CYC(10)) u_pulse_level_conv (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulse_in(pulse_in), .hoa_hand(hoa_hand), .hoa_off(hoa_off), .out_level(out_level),
    .led_in(led_in), .led_out(led_out), .led_beat(led_beat), .load_window(load_window), .irq(irq));
  pulse_ctrl_model u_pulse_ctrl_model (.pulse_in(pulse_in), .clk(clk));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic [6:0] exp_level(input int ticks);
    return ticks < 10 ? 7'h00 : ticks >= 100 ? 7'h64 : 7'(ticks);
  endfunction
  // tick quantisation allows one step either way, never at the clamps
  function automatic logic [6:0] near(input logic [6:0] e, input logic [6:0] g);
    return (e != 7'h00 && e != 7'h64 && (g === e + 7'h01 || g === e - 7'h01)) ? e : g;
  endfunction
  task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rises(input bit sel, input int cyc);
    logic p, c;
    n = 0;
    @(posedge clk);
    p = sel ? led_in[0] : led_beat;
    repeat (cyc) begin
      @(posedge clk);
      c = sel ? led_in[0] : led_beat;
      if (c === 1'b1 && p !== 1'b1) n++;
      p = c;
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h86B9;
    {rstn, psel, penable, pwrite, paddr, pwdata, hoa_hand, hoa_off} = '0;
    n_fail = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("load_window", 1'b1, load_window);
    rises(0, 10 * T);
    chk("beat pairs", 2, n);
    apb(0, 12'h050, 0);
    chk("hand0 reset", 32'h64, rd);
    apb(0, 12'h010, 0);
    chk("mode0 reset", 32'h2, rd);
    apb(0, 12'h004, 0);
    chk("status load", 1'b1, rd[0]);
    apb(1, 12'h000, 32'h1);
    apb(0, 12'h004, 0);
    chk("loaded", 1'b1, rd[1]);
    apb(0, 12'hFFC, 0);
    chk("unmapped err", 1'b1, err);
    chk("unmapped rdata", 32'h0, rd);
    hoa_off[0] <= 1'b1;
    repeat (10) @(posedge clk);
    chk("off level", 7'h00, out_level[0]);
    hoa_off[0] <= 1'b0;
    d = '{120, 5, 40, 0, 0, 0};
    for (int c = 3; c < 6; c++) d[c] = 12 + ({$random(seed)} % 84);
    u_pulse_ctrl_model.burst('{d[0] * T, d[1] * T, d[2] * T, d[3] * T, d[4] * T, d[5] * T}, 6'h04);
    repeat (40) @(posedge clk);
    for (int c = 0; c < 6; c++) chk("level", exp_level(d[c]), near(exp_level(d[c]), out_level[c]));
    hoa_off[0] <= 1'b1;
    repeat (6) @(posedge clk);
    chk("off after auto", 7'h00, out_level[0]);
    hoa_off[0] <= 1'b0;
    repeat (6) @(posedge clk);
    chk("auto restored", 7'h64, out_level[0]);
    chk("window end", 1'b0, load_window);
    apb(1, 12'h000, 32'h1);
    apb(0, 12'h000, 0);
    chk("late load", 32'h0, rd);
    chk("irq masked", 1'b0, irq);
    apb(1, 12'h00C, 32'h3F);
    repeat (3) @(posedge clk);
    chk("irq raised", 1'b1, irq);
    apb(0, 12'h008, 0);
    chk("done bits", 6'h3F, rd[5:0]);
    apb(1, 12'h008, 32'h3F);
    repeat (3) @(posedge clk);
    chk("irq cleared", 1'b0, irq);
    hoa_hand[1] <= 1'b1;
    apb(1, 12'h054, 32'h37);
    repeat (4) @(posedge clk);
    chk("hand level", 7'h37, out_level[1]);
    apb(1, 12'h054, 32'hFF);
    apb(0, 12'h054, 0);
    chk("hand clamp", 32'h64, rd);
    hoa_hand[1] <= 1'b0;
    rises(0, 20 * T);
    chk("beat normal", 2, n);
    repeat (605 * T) @(posedge clk);
    for (int c = 0; c < 6; c++) chk("lost level", 7'h00, out_level[c]);
    apb(0, 12'h004, 0);
    chk("lost bits", 6'h3F, rd[13:8]);
    rises(1, 10 * T);
    chk("lost flash", 4, n);
    fork
      u_pulse_ctrl_model.burst('{20 * T, 0, 0, 0, 0, 0}, 6'h00);
      begin
        repeat (T) @(posedge clk);
        chk("led follows", 1'b1, led_in[0]);
      end
    join
    repeat (40) @(posedge clk);
    chk("relevel", 7'h14, near(7'h14, out_level[0]));
    apb(0, 12'h004, 0);
    chk("lost clear", 1'b0, rd[8]);
    apb(1, 12'h010, 32'h0);
    repeat (3) @(posedge clk);
    chk("reg off", 7'h00, out_level[0]);
    apb(1, 12'h010, 32'h12);
    repeat (3) @(posedge clk);
    chk("bin led", 1'b0, led_in[0]);
    apb(1, 12'h010, 32'h112);
    repeat (3) @(posedge clk);
    chk("bin inv", 1'b1, led_in[0]);
    chk("auto back", 7'h14, near(7'h14, out_level[0]));
    apb(1, 12'h070, 32'h37);
    apb(1, 12'h010, 32'h22);
    repeat (3) @(posedge clk);
    n = 0;
    m = 0;
    repeat (100) begin
      @(posedge clk);
      if (led_in[0] === 1'b1) n++;
      if (led_out[0] === 1'b1) m++;
    end
    chk("ana duty", 50, n);
    chk("out duty", 7'h14, near(7'h14, 7'(m)));
    print_verdict();
  end
  initial begin
    repeat (95000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule
